// File: verilog/pdl_top.sv
`timescale 1ns/1ps
// How it works
// - divide ratio equals swallow count plus 128 times main count from the word.
// - select bits pick reference 50k, 25k, 12.5k or 6.25k.
// - port outputs follow the two port bits of the word independently.
// - polarity high: detector low while divided input lags, high while it leads.
// - lock pulled low once phase error stays under 625ns beyond three periods.
// - polarity low inverts the detector output sense.
// - serial data bit shifted in on each falling serial clock edge.
// - word takes effect on the 21st falling edge; further pulses ignored.
// - load reset high blocks clock and data and clears the pulse counter.
// - test high routes reference to port one and divided input to port two.
module pdl_top
    import pdl_pkg::*;
#(
    parameter int REF_BASE_CYC = pdl_pkg::REF_CYC_BASE, // cycles per 50k period
    parameter int LOCK_CYC = pdl_pkg::LOCK_ERR_CYC // longest tolerated error
) (
    input wire logic I_CLK_SYS, // system clock 25 MHz
    input wire logic I_RST_B, // async reset, active low
    input wire logic I_SERIAL_CLOCK, // serial clock pin
    input wire logic I_SERIAL_DATA, // serial data pin
    input wire logic I_LOAD_RST, // word load reset pin, high blocks input
    input wire logic I_POLARITY, // detector polarity pin
    input wire logic I_TEST, // test pin
    input wire logic I_LO_IN, // prescaled local oscillator input
    input wire pdl_pkg::pdl_bus_s I_BUS, // register port request
    output logic [31:0] O_RDATA, // register read data, cycle after read
    output logic O_IRQ, // level interrupt
    output logic O_OUTPUT_PORT_ONE, // first output port level
    output logic O_OUTPUT_PORT_TWO, // second output port level
    output logic O_PHASE_DETECTOR_OUT, // detector output value
    output logic O_PHASE_DETECTOR_OE, // detector output enable
    output logic O_LOCK_N_OUT, // lock pin value, always low
    output logic O_LOCK_N_OE // lock pin pull-down enable
);
    import pdl_pkg::*;

    // ------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------
    if ((REF_BASE_CYC < 2) || ((REF_BASE_CYC * 8) >= (1 << REF_CNT_W))) begin : g_bad_ref
        $error("reference base count out of range");
    end
    if ((LOCK_CYC < 1) || (LOCK_CYC > 30)) begin : g_bad_lock
        $error("lock error count out of range");
    end

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [2:0] sck;
        logic [1:0] sdat;
        logic [1:0] lrst;
        logic [2:0] lo;
        logic [1:0] pol;
        logic [1:0] tst;
        logic [WORD_LEN-1:0] shreg;
        logic [4:0] pulses;
        pdl_cfg_s cfg;
        logic [REF_CNT_W-1:0] refcnt;
        logic ref_sq;
        logic [RATIO_W-1:0] divcnt;
        logic div_sq;
        logic up;
        logic dn;
        logic [4:0] errcnt;
        logic bad;
        logic [2:0] good;
        logic locked;
        logic pd_o;
        logic pd_oe;
        logic port_one;
        logic port_two;
        logic [EVT_W-1:0] status;
        logic [EVT_W-1:0] mask;
        logic irq;
        logic [31:0] rdata;
    } pdl_state_s;

    pdl_state_s q;
    pdl_state_s d;

    localparam pdl_state_s STATE_RST = '{
        cfg: '{port_two: 1'b0, port_one: 1'b0, ref_sel: 2'h0, main_cnt: RST_MAIN, swallow_cnt: 7'h00},
        mask: RST_MASK,
        default: '0
    };

    logic sck_fall;
    logic ref_pulse;
    logic div_pulse;
    logic [REF_CNT_W-1:0] ref_last;
    logic [RATIO_W-1:0] ratio;
    logic up_n;
    logic dn_n;
    logic bad_n;
    logic [EVT_W-1:0] evt;
    logic [EVT_W-1:0] w1c;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        d = q;
        // synchronisers; stage one feeds stage two only
        d.sck = {q.sck[1:0], I_SERIAL_CLOCK};
        d.sdat = {q.sdat[0], I_SERIAL_DATA};
        d.lrst = {q.lrst[0], I_LOAD_RST};
        d.lo = {q.lo[1:0], I_LO_IN};
        d.pol = {q.pol[0], I_POLARITY};
        d.tst = {q.tst[0], I_TEST};
        evt = '0;

        // serial word intake
        sck_fall = q.sck[2] & ~q.sck[1];
        if (q.lrst[1]) begin
            d.pulses = '0;
        end else if (sck_fall && (q.pulses < 5'(WORD_LEN))) begin
            d.shreg = {q.shreg[WORD_LEN-2:0], q.sdat[1]};
            d.pulses = q.pulses + 5'h01;
            if (q.pulses == 5'(WORD_LEN - 1)) begin
                d.cfg = pdl_cfg_s'({q.shreg[WORD_LEN-2:0], q.sdat[1]});
                evt[EVT_LOADED] = 1'b1;
            end
        end

        // reference divider
        ref_last = REF_CNT_W'((REF_BASE_CYC << q.cfg.ref_sel) - 1);
        ref_pulse = (q.refcnt >= ref_last);
        d.refcnt = ref_pulse ? '0 : q.refcnt + 1'b1;
        if (ref_pulse) begin
            d.ref_sq = ~q.ref_sq;
        end

        // programmable divider on rising input edges
        ratio = RATIO_W'(q.cfg.swallow_cnt) + RATIO_W'(q.cfg.main_cnt) * RATIO_W'(MAIN_MULT);
        div_pulse = 1'b0;
        if (q.lo[1] & ~q.lo[2]) begin
            div_pulse = (q.divcnt + 1'b1 >= ratio);
            d.divcnt = div_pulse ? '0 : q.divcnt + 1'b1;
            if (div_pulse) begin
                d.div_sq = ~q.div_sq;
            end
        end

        // phase detector: up = reference first, dn = divided input first
        up_n = q.up | ref_pulse;
        dn_n = q.dn | div_pulse;
        if (up_n & dn_n) begin
            up_n = 1'b0;
            dn_n = 1'b0;
        end
        d.up = up_n;
        d.dn = dn_n;
        d.pd_oe = up_n ^ dn_n;
        d.pd_o = (up_n ^ dn_n) ? (dn_n ~^ q.pol[1]) : 1'b0;

        // lock detector
        d.errcnt = (up_n | dn_n) ? ((q.errcnt == 5'h1f) ? q.errcnt : q.errcnt + 5'h01) : 5'h00;
        // an error of exactly LOCK_CYC cycles is still under the limit
        bad_n = q.bad | (d.errcnt > 5'(LOCK_CYC));
        d.bad = bad_n;
        if (ref_pulse) begin
            d.bad = 1'b0;
            d.good = bad_n ? 3'h0 : ((q.good == 3'h7) ? q.good : q.good + 3'h1);
        end
        d.locked = (d.good > 3'(LOCK_PERIODS));
        evt[EVT_LOCK] = d.locked & ~q.locked;
        evt[EVT_UNLOCK] = ~d.locked & q.locked;

        // port outputs, test mode routing
        d.port_one = q.tst[1] ? q.ref_sq : q.cfg.port_one;
        d.port_two = q.tst[1] ? q.div_sq : q.cfg.port_two;

        // register port
        w1c = (I_BUS.wr && (I_BUS.addr == REG_STATUS)) ? I_BUS.wdata[EVT_W-1:0] : '0;
        d.status = (q.status & ~w1c) | evt; // a new event beats a clear
        if (I_BUS.wr && (I_BUS.addr == REG_MASK)) begin
            d.mask = I_BUS.wdata[EVT_W-1:0];
        end
        d.irq = |(d.status & d.mask);
        d.rdata = '0;
        if (I_BUS.rd) begin
            case (I_BUS.addr)
                REG_STATUS: d.rdata = 32'(q.status);
                REG_MASK: d.rdata = 32'(q.mask);
                REG_STATE: d.rdata = 32'({q.pulses, q.pd_o, q.pd_oe, q.port_two, q.port_one, q.locked});
                REG_WORD: d.rdata = 32'(q.cfg);
                default: d.rdata = '0;
            endcase
        end
    end

    always_ff @(posedge I_CLK_SYS or negedge I_RST_B) begin
        if (!I_RST_B) begin
            q <= STATE_RST;
        end else begin
            q <= d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign O_RDATA = q.rdata;
    assign O_IRQ = q.irq;
    assign O_OUTPUT_PORT_ONE = q.port_one;
    assign O_OUTPUT_PORT_TWO = q.port_two;
    assign O_PHASE_DETECTOR_OUT = q.pd_o;
    assign O_PHASE_DETECTOR_OE = q.pd_oe;
    assign O_LOCK_N_OUT = 1'b0 & q.locked; // open collector only pulls low
    assign O_LOCK_N_OE = q.locked;

endmodule

// File: verilog/pdl_pkg.sv
package pdl_pkg;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_HZ = 25_000_000;
    localparam int CLK_PERIOD_NS = 40;
    localparam int REF_HZ_BASE = 50_000;
    localparam int REF_CYC_BASE = CLK_HZ / REF_HZ_BASE;
    localparam int REF_CNT_W = 12;
    // longest allowed phase error rounds down to whole cycles
    localparam int LOCK_ERR_NS = 625;
    localparam int LOCK_ERR_CYC = (LOCK_ERR_NS / CLK_PERIOD_NS) < 1 ? 1 : (LOCK_ERR_NS / CLK_PERIOD_NS);
    localparam int LOCK_PERIODS = 3;

    // ------------------------------------------------------------
    // serial control word
    // ------------------------------------------------------------
    localparam int WORD_LEN = 21;
    localparam int SWALLOW_W = 7;
    localparam int MAIN_W = 10;
    localparam int RATIO_W = SWALLOW_W + MAIN_W;
    localparam int MAIN_MULT = 128;
    localparam logic [MAIN_W-1:0] RST_MAIN = 10'h001;

    // word bit 0 is the last bit shifted in
    typedef struct packed {
        logic port_two;
        logic port_one;
        logic [1:0] ref_sel;
        logic [MAIN_W-1:0] main_cnt;
        logic [SWALLOW_W-1:0] swallow_cnt;
    } pdl_cfg_s;

    // ------------------------------------------------------------
    // register port
    // ------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] REG_STATUS = 8'h00;
    localparam logic [ADDR_W-1:0] REG_MASK = 8'h04;
    localparam logic [ADDR_W-1:0] REG_STATE = 8'h08;
    localparam logic [ADDR_W-1:0] REG_WORD = 8'h0c;
    localparam int EVT_W = 3;
    localparam int EVT_LOADED = 0;
    localparam int EVT_LOCK = 1;
    localparam int EVT_UNLOCK = 2;
    localparam logic [EVT_W-1:0] RST_MASK = 3'h0;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } pdl_bus_s;

endpackage

// File: dv/pdl_top_sva.sv
`timescale 1ns/1ps
// ----------------------------------------
// port checker
// ----------------------------------------
module pdl_top_sva
    import pdl_pkg::*;
#(
    parameter int REF_BASE_CYC = 10, // base ref period
    parameter int LOCK_CYC = 15 // error limit
) (
    input wire logic I_CLK_SYS, // clock
    input wire logic I_RST_B, // reset
    input wire logic I_LOAD_RST, // load reset
    input wire logic I_POLARITY, // polarity
    input wire logic I_TEST, // test
    input wire logic I_LO_IN, // oscillator
    input wire pdl_pkg::pdl_bus_s I_BUS, // bus
    input wire logic [31:0] O_RDATA, // read data
    input wire logic O_OUTPUT_PORT_ONE, // port one
    input wire logic O_OUTPUT_PORT_TWO, // port two
    input wire logic O_PHASE_DETECTOR_OUT, // pd value
    input wire logic O_PHASE_DETECTOR_OE, // pd enable
    input wire logic O_LOCK_N_OUT, // lock value
    input wire logic O_LOCK_N_OE // lock enable
);
    localparam int TW = REF_BASE_CYC * 8 + 20;
    // run: unbroken pd drive; age: since last long error; still: oscillator idle
    logic [11:0] run_q;
    logic [11:0] age_q;
    logic [11:0] still_q;
    default clocking @(posedge I_CLK_SYS); endclocking
    default disable iff (!I_RST_B);
    always_ff @(posedge I_CLK_SYS or negedge I_RST_B) begin
        if (!I_RST_B) begin
            run_q <= 12'h000;
            age_q <= 12'h000;
            still_q <= 12'h000;
        end else begin
            run_q <= O_PHASE_DETECTOR_OE ? run_q + 12'h001 : 12'h000;
            age_q <= (run_q >= 12'(LOCK_CYC + 2)) ? 12'h000 : age_q + 12'(age_q != 12'hfff);
            still_q <= $changed(I_LO_IN) ? 12'h000 : still_q + 12'(still_q != 12'hfff);
        end
    end
    a_lock_pin_low: assert property (O_LOCK_N_OUT == 1'b0) else $error("lock value not low");
    a_lock_loss: assert property (run_q == 12'(LOCK_CYC + 2) |-> ##[0:TW] !O_LOCK_N_OE)
        else $error("lock kept over long error");
    a_lock_gain: assert property ($rose(O_LOCK_N_OE) |-> age_q > 12'(3 * REF_BASE_CYC))
        else $error("lock came too soon");
    a_ports_hold: assert property ((I_LOAD_RST && !I_TEST)[*8] |=> $stable(O_OUTPUT_PORT_ONE)
        && $stable(O_OUTPUT_PORT_TWO)) else $error("ports moved while load blocked");
    a_test_toggle: assert property ($rose(I_TEST) ##8 I_TEST |-> ##[0:TW] $changed(O_OUTPUT_PORT_ONE))
        else $error("no reference on port one");
    a_pd_steady: assert property ($stable(I_POLARITY)[*6] ##0 (O_PHASE_DETECTOR_OE &&
        $past(O_PHASE_DETECTOR_OE)) |-> $stable(O_PHASE_DETECTOR_OUT)) else $error("pd value moved");
    a_pd_lag: assert property ($stable(I_POLARITY)[*6] ##0 (still_q > 12'(TW) && O_PHASE_DETECTOR_OE)
        |-> O_PHASE_DETECTOR_OUT == !I_POLARITY) else $error("pd lag level wrong");
    a_rdata_idle: assert property (!$past(I_BUS.rd) |-> O_RDATA == 32'h0) else $error("read data not idle");
endmodule

bind pdl_top pdl_top_sva #(.REF_BASE_CYC(REF_BASE_CYC), .LOCK_CYC(LOCK_CYC)) i_sva (
    .I_CLK_SYS(I_CLK_SYS),
    .I_RST_B(I_RST_B),
    .I_LOAD_RST(I_LOAD_RST),
    .I_POLARITY(I_POLARITY),
    .I_TEST(I_TEST),
    .I_LO_IN(I_LO_IN),
    .I_BUS(I_BUS),
    .O_RDATA(O_RDATA),
    .O_OUTPUT_PORT_ONE(O_OUTPUT_PORT_ONE),
    .O_OUTPUT_PORT_TWO(O_OUTPUT_PORT_TWO),
    .O_PHASE_DETECTOR_OUT(O_PHASE_DETECTOR_OUT),
    .O_PHASE_DETECTOR_OE(O_PHASE_DETECTOR_OE),
    .O_LOCK_N_OUT(O_LOCK_N_OUT),
    .O_LOCK_N_OE(O_LOCK_N_OE)
);

// File: dv/pdl_ctrl_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// serial controller model
// ----------------------------------------
module pdl_ctrl_model (
    input wire logic clk, // system clock
    output logic sclk, // serial clock, idles high
    output logic sdata, // serial data
    output logic load_rst // load reset
);
    initial begin
        sclk = 1'b1;
        sdata = 1'b0;
        load_rst = 1'b1;
    end
    // each level held 4 cycles to outlast the input synchronisers
    task automatic send(input logic [20:0] w, input int n, input logic blk);
        repeat (4) @(posedge clk);
        load_rst <= blk;
        for (int i = 0; i < n; i++) begin
            sdata <= (i < 21) ? w[20 - i] : ~sdata;
            repeat (4) @(posedge clk);
            sclk <= 1'b0;
            repeat (4) @(posedge clk);
            sclk <= 1'b1;
            repeat (4) @(posedge clk);
        end
        load_rst <= 1'b1;
    endtask
endmodule

// File: dv/tb.sv
`timescale 1ns/1ps
module tb;
    import pdl_pkg::*;
    logic clk, rst_b, pol, test, lo, lo_en, sclk, sdata, lrst, p1, p2, pdo, pde, lko, lke, irq;
    logic [31:0] rdata;
    logic [20:0] w;
    pdl_bus_s bus;
    int num_errors = 0;
    int n_compared = 0;
    int lo_cnt = 0;
    pdl_ctrl_model i_ctrl (.clk(clk), .sclk(sclk), .sdata(sdata), .load_rst(lrst));
    pdl_top #(.REF_BASE_CYC(10), .LOCK_CYC(15)) i_dut (.I_CLK_SYS(clk), .I_RST_B(rst_b),
        .I_SERIAL_CLOCK(sclk), .I_SERIAL_DATA(sdata), .I_LOAD_RST(lrst), .I_POLARITY(pol),
        .I_TEST(test), .I_LO_IN(lo), .I_BUS(bus), .O_RDATA(rdata), .O_IRQ(irq),
        .O_OUTPUT_PORT_ONE(p1), .O_OUTPUT_PORT_TWO(p2), .O_PHASE_DETECTOR_OUT(pdo),
        .O_PHASE_DETECTOR_OE(pde), .O_LOCK_N_OUT(lko), .O_LOCK_N_OE(lke));
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // oscillator at a fifth of the clock keeps it under the sampling limit
    always @(posedge clk) begin
        lo_cnt <= (lo_cnt + 1) % 5;
        lo <= lo_en && lo_cnt < 2;
    end
    task automatic summarize();
        $display("errors %0d compared %0d", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic acc(input logic [7:0] a, input logic [31:0] d, input logic r);
        @(posedge clk);
        bus <= '{a, d, !r, r};
        @(posedge clk);
        bus <= '0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        acc(a, 32'h0, 1'b1);
        check(rdata, exp);
    endtask
    // watched outputs: 0 port one, 1 port two, 2 lock enable, 3 detector enable
    function automatic logic pick(input int k);
        case (k)
            0: return p1;
            1: return p2;
            2: return lke;
            default: return pde;
        endcase
    endfunction
    // outputs are looked at 1 ns after the edge, once settled
    task automatic wt(input int k, input logic v);
        int n;
        for (n = 0; pick(k) !== v && n < 3000; n++) begin
            @(posedge clk);
            #1;
        end
        check(pick(k), v);
        if (n == 3000) summarize();
    endtask
    // first two intervals dropped: they may start at the mode switch
    task automatic per(input int k, input int exp);
        int n;
        logic v;
        for (int j = 0; j < 3; j++) begin
            v = pick(k);
            for (n = 0; pick(k) === v && n < 3000; n++) begin
                @(posedge clk);
                #1;
            end
            if (n == 3000) begin
                num_errors++;
                summarize();
            end
        end
        check(n, exp);
    endtask
    initial begin
        rst_b = 1'b0;
        pol = 1'b1;
        test = 1'b0;
        lo_en = 1'b1;
        bus = '0;
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        rd(REG_WORD, 32'h80);
        rd(8'h10, 32'h0);
        for (int i = 0; i < 4; i++) begin
            w = {i[1:0], i[1:0], (i == 3) ? 10'h1 : 10'h0, 7'(i + 2)};
            i_ctrl.send(w, 21 + i, 1'b0);
            rd(REG_WORD, {11'h0, w});
            check({p2, p1}, i[1:0]);
            @(posedge clk);
            test <= 1'b1;
            per(0, 10 << i);
            per(1, 5 * (i + 2 + ((i == 3) ? 128 : 0)));
            @(posedge clk);
            test <= 1'b0;
        end
        i_ctrl.send(21'h0, 21, 1'b1);
        rd(REG_WORD, {11'h0, w});
        check(irq, 1'b0);
        acc(REG_MASK, 32'h1, 1'b0);
        check(irq, 1'b1);
        acc(REG_STATUS, 32'h1, 1'b0);
        check(irq, 1'b0);
        i_ctrl.send(21'h2, 21, 1'b0);
        wt(2, 1'b1);
        lo_en <= 1'b0;
        repeat (30) @(posedge clk);
        wt(3, 1'b1);
        check(pdo, 1'b0);
        @(posedge clk);
        pol <= 1'b0;
        repeat (6) @(posedge clk);
        #1 check(pdo, 1'b1);
        wt(2, 1'b0);
        // oscillator kept still long enough for the lag checker to engage
        repeat (120) @(posedge clk);
        pol <= 1'b1;
        lo_en <= 1'b1;
        // ratio 1 against the fastest reference: divided input always leads
        i_ctrl.send(21'h1, 21, 1'b0);
        repeat (30) @(posedge clk);
        wt(3, 1'b1);
        check(pdo, 1'b1);
        summarize();
    end
endmodule
